// [rtl/ecd_pkg.sv]
// shared constants, states and carriers for the 8-bit core decoder
package ecd_pkg;

    // opcodes that stand alone (implied and relative forms)
    localparam logic [7:0] OP_DOUBLE_SHIFT_RIGHT = 8'h04;
    localparam logic [7:0] OP_DOUBLE_SHIFT_LEFT  = 8'h05;
    localparam logic [7:0] OP_BRANCH_ALWAYS      = 8'h20;
    localparam logic [7:0] OP_BRANCH_NEVER       = 8'h21;
    localparam logic [7:0] OP_STACK_TO_INDEX     = 8'h30;
    localparam logic [7:0] OP_INDEX_TO_STACK     = 8'h35;
    localparam logic [7:0] OP_PULL_INDEX         = 8'h38;
    localparam logic [7:0] OP_ADD_B_TO_INDEX     = 8'h3a;
    localparam logic [7:0] OP_PUSH_INDEX         = 8'h3c;
    localparam logic [7:0] OP_PRODUCT            = 8'h3d;

    // low nibble of the memory-operand families
    localparam logic [3:0] LO_SUB_OR_ADD   = 4'h3;  // 8x-Bx sub, Cx-Fx add
    localparam logic [3:0] LO_CMP_OR_LOAD  = 4'hc;  // 8x-Bx cmp, Cx-Fx load
    localparam logic [3:0] LO_STORE        = 4'hd;  // Dx, Ex, Fx only

    // addressing mode taken from opcode bits 5:4
    localparam logic [1:0] MODE_IMMEDIATE  = 2'h0;
    localparam logic [1:0] MODE_DIRECT     = 2'h1;
    localparam logic [1:0] MODE_INDEXED    = 2'h2;
    localparam logic [1:0] MODE_EXTENDED   = 2'h3;

    // condition code bit positions
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DACC   = 8'h08;
    localparam logic [7:0] REG_INDEX  = 8'h0c;
    localparam logic [7:0] REG_STACK  = 8'h10;
    localparam logic [7:0] REG_PC     = 8'h14;
    localparam logic [7:0] REG_CCR    = 8'h18;

    // values after reset
    localparam logic [15:0] RST_PC  = 16'h0000;
    localparam logic [15:0] RST_SP  = 16'h00ff;
    localparam logic [7:0]  RST_CCR = 8'hd0;

    // sequencer states
    typedef enum logic [3:0] {
        ST_FETCH   = 4'h0,
        ST_OPND_HI = 4'h1,
        ST_OPND_LO = 4'h2,
        ST_REL     = 4'h3,
        ST_RD_HI   = 4'h4,
        ST_RD_LO   = 4'h5,
        ST_WR_HI   = 4'h6,
        ST_WR_LO   = 4'h7,
        ST_EXEC    = 4'h8,
        ST_PUSH_LO = 4'h9,
        ST_PUSH_HI = 4'ha,
        ST_PULL_HI = 4'hb,
        ST_PULL_LO = 4'hc
    } ecd_state_e;

    // one memory request toward the system bus
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ecd_mem_s;

    // whole state of the core
    typedef struct packed {
        ecd_state_e  st;
        logic [7:0]  op;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] x;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  cc;
        logic [15:0] ea;
        logic [15:0] m;
        ecd_mem_s    mem;
        logic        run;
        logic [31:0] prdata;
        logic        perr;
    } ecd_core_s;

endpackage

// [rtl/ecd_core.sv]
// 8-bit core: address modes, 16-bit ops, apb debug and control slave
//
// Functional notes
// - direct mode address is 00 then byte two
// - extended address is byte two then three
// - indexed adds byte to index into temp
// - implied opcodes are one byte, no operands
// - relative target is pc plus two plus offset
// - opcode 3a adds unsigned b into index
// - double add sums memory word into d
// - double left shift, zero in, msb to carry
// - double right shift, zero in, lsb to carry
// - product of a and b, high in a
// - push index low then high, sp minus two
// - pull index high then low, sp plus two
// - double store a then b, sets nz, clears v
// - double subtract memory word from d, nzvc
// - branch never is a two byte no-op
// - index compare sets nzvc, stores nothing
// - d is a high, b low
// - opcode 35 loads sp with index minus one
// - opcode 30 loads index with sp plus one
// - affected flags set if test true, else cleared
module ecd_core (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic                 pready,
    output logic [31:0]          prdata,
    output logic                 pslverr,
    // memory bus
    output ecd_pkg::ecd_mem_s    mem_o,
    input  wire logic            mem_ready,
    input  wire logic [7:0]      mem_rdata
);
    import ecd_pkg::*;

    ecd_core_s   s;          // registered state
    ecd_core_s   n;          // next state

    logic        is_mem;     // current state needs a bus access
    logic        go;         // access finished this cycle
    logic [15:0] acc_addr;   // address of the access
    logic        acc_we;     // access is a write
    logic [7:0]  acc_wdata;  // byte to write
    logic [15:0] d;          // double accumulator view
    logic [16:0] add_r;      // d plus memory word
    logic [16:0] sub_r;      // d minus memory word
    logic [16:0] cmp_r;      // index minus memory word
    logic [15:0] prod;       // a times b
    logic [15:0] shl_r;      // d shifted left
    logic [15:0] shr_r;      // d shifted right
    logic [15:0] rel_pc;     // branch target
    logic        memop;      // opcode takes a memory operand
    logic        store_op;   // opcode writes a memory word
    logic [1:0]  mode;       // addressing mode field
    logic        setup;      // apb setup cycle
    logic        wr_acc;     // apb write access phase

    // combined views and arithmetic, kept outside the state process
    assign d      = {s.a, s.b};
    assign add_r  = {1'b0, d} + {1'b0, s.m};
    assign sub_r  = {1'b0, d} - {1'b0, s.m};
    assign cmp_r  = {1'b0, s.x} - {1'b0, s.m};
    assign prod   = 16'(s.a) * 16'(s.b);
    assign shl_r  = {d[14:0], 1'b0};
    assign shr_r  = {1'b0, d[15:1]};
    // pc holds the offset byte's address, so one more is base plus two
    assign rel_pc = 16'(s.pc + 16'd1 + {{8{mem_rdata[7]}}, mem_rdata});
    assign mode   = s.op[5:4];
    assign store_op = (s.op[3:0] == LO_STORE);
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;

    // memory-operand decode works on the byte arriving from the bus
    always_comb begin
        memop = 1'b0;
        if (mem_rdata[7]) begin
            case (mem_rdata[3:0])
                LO_SUB_OR_ADD:  memop = 1'b1;
                LO_CMP_OR_LOAD: memop = 1'b1;
                // store has no immediate form and lives in the upper half
                LO_STORE: memop = mem_rdata[6] & (mem_rdata[5:4] != 2'h0);
                default:        memop = 1'b0;
            endcase
        end
    end

    // address, direction and data for each bus state
    always_comb begin
        is_mem    = 1'b1;
        acc_addr  = s.pc;
        acc_we    = 1'b0;
        acc_wdata = 8'h00;
        case (s.st)
            // a request already out must finish even if run drops
            ST_FETCH:   is_mem = s.run | s.mem.req;
            ST_OPND_HI: acc_addr = s.pc;
            ST_OPND_LO: acc_addr = s.pc;
            ST_REL:     acc_addr = s.pc;
            ST_RD_HI:   acc_addr = s.ea;
            ST_RD_LO:   acc_addr = 16'(s.ea + 16'd1);
            ST_WR_HI: begin
                acc_addr  = s.ea;
                acc_we    = 1'b1;
                acc_wdata = s.a;
            end
            ST_WR_LO: begin
                acc_addr  = 16'(s.ea + 16'd1);
                acc_we    = 1'b1;
                acc_wdata = s.b;
            end
            ST_PUSH_LO: begin
                acc_addr  = s.sp;
                acc_we    = 1'b1;
                acc_wdata = s.x[7:0];
            end
            ST_PUSH_HI: begin
                acc_addr  = s.sp;
                acc_we    = 1'b1;
                acc_wdata = s.x[15:8];
            end
            ST_PULL_HI: acc_addr = 16'(s.sp + 16'd1);
            ST_PULL_LO: acc_addr = 16'(s.sp + 16'd1);
            default:    is_mem = 1'b0;
        endcase
        go = is_mem & s.mem.req & mem_ready;
    end

    // sequencer, execution and register slave in one next-state process
    always_comb begin
        n = s;
        // raise a request one cycle, drop it on the cycle ready is seen
        if (is_mem && !s.mem.req) begin
            n.mem.req   = 1'b1;
            n.mem.we    = acc_we;
            n.mem.addr  = acc_addr;
            n.mem.wdata = acc_wdata;
        end
        if (go) begin
            n.mem.req = 1'b0;
            n.mem.we  = 1'b0;
        end

        case (s.st)
            // opcode byte
            ST_FETCH: begin
                if (go) begin
                    n.op = mem_rdata;
                    n.pc = 16'(s.pc + 16'd1);
                    if (memop) begin
                        if (mem_rdata[5:4] == MODE_IMMEDIATE) begin
                            // immediate word sits right after the opcode
                            n.ea = 16'(s.pc + 16'd1);
                            n.pc = 16'(s.pc + 16'd3);
                            n.st = ST_RD_HI;
                        end else begin
                            n.st = ST_OPND_HI;
                        end
                    end else if (mem_rdata == OP_BRANCH_ALWAYS ||
                                 mem_rdata == OP_BRANCH_NEVER) begin
                        n.st = ST_REL;
                    end else if (mem_rdata == OP_PUSH_INDEX) begin
                        n.st = ST_PUSH_LO;
                    end else if (mem_rdata == OP_PULL_INDEX) begin
                        n.st = ST_PULL_HI;
                    end else begin
                        n.st = ST_EXEC;
                    end
                end
            end
            // second instruction byte
            ST_OPND_HI: begin
                if (go) begin
                    n.pc = 16'(s.pc + 16'd1);
                    case (mode)
                        MODE_DIRECT: begin
                            n.ea = {8'h00, mem_rdata};
                            n.st = store_op ? ST_WR_HI : ST_RD_HI;
                        end
                        MODE_INDEXED: begin
                            // index register itself is left untouched
                            n.ea = 16'(s.x + {8'h00, mem_rdata});
                            n.st = store_op ? ST_WR_HI : ST_RD_HI;
                        end
                        default: begin
                            n.ea[15:8] = mem_rdata;
                            n.st       = ST_OPND_LO;
                        end
                    endcase
                end
            end
            // third byte, extended mode only
            ST_OPND_LO: begin
                if (go) begin
                    n.pc      = 16'(s.pc + 16'd1);
                    n.ea[7:0] = mem_rdata;
                    n.st      = store_op ? ST_WR_HI : ST_RD_HI;
                end
            end
            // branch offset byte
            ST_REL: begin
                if (go) begin
                    n.pc = 16'(s.pc + 16'd1);
                    if (s.op == OP_BRANCH_ALWAYS) begin
                        n.pc = rel_pc;
                    end
                    // branch never only skips its offset, flags kept
                    n.st = ST_FETCH;
                end
            end
            // operand word, high byte first
            ST_RD_HI: begin
                if (go) begin
                    n.m[15:8] = mem_rdata;
                    n.st      = ST_RD_LO;
                end
            end
            ST_RD_LO: begin
                if (go) begin
                    n.m[7:0] = mem_rdata;
                    n.st     = ST_EXEC;
                end
            end
            // double store, a then b
            ST_WR_HI: begin
                if (go) begin
                    n.st = ST_WR_LO;
                end
            end
            ST_WR_LO: begin
                if (go) begin
                    n.cc[CC_N] = d[15];
                    n.cc[CC_Z] = (d == 16'h0000);
                    n.cc[CC_V] = 1'b0;
                    n.st       = ST_FETCH;
                end
            end
            // push index, low byte at the current stack pointer
            ST_PUSH_LO: begin
                if (go) begin
                    n.sp = 16'(s.sp - 16'd1);
                    n.st = ST_PUSH_HI;
                end
            end
            ST_PUSH_HI: begin
                if (go) begin
                    n.sp = 16'(s.sp - 16'd1);
                    n.st = ST_FETCH;
                end
            end
            // pull index, high byte from sp plus one
            ST_PULL_HI: begin
                if (go) begin
                    n.sp      = 16'(s.sp + 16'd1);
                    n.x[15:8] = mem_rdata;
                    n.st      = ST_PULL_LO;
                end
            end
            ST_PULL_LO: begin
                if (go) begin
                    n.sp     = 16'(s.sp + 16'd1);
                    n.x[7:0] = mem_rdata;
                    n.st     = ST_FETCH;
                end
            end
            // register-only work, one cycle, no bus access
            ST_EXEC: begin
                n.st = ST_FETCH;
                if (s.op[7] && s.op[7:6] == 2'h2 &&
                    s.op[3:0] == LO_SUB_OR_ADD) begin
                    {n.a, n.b} = sub_r[15:0];
                    n.cc[CC_N] = sub_r[15];
                    n.cc[CC_Z] = (sub_r[15:0] == 16'h0000);
                    n.cc[CC_V] = (d[15] ^ s.m[15]) & (sub_r[15] ^ d[15]);
                    n.cc[CC_C] = sub_r[16];
                end else if (s.op[7:6] == 2'h2 &&
                             s.op[3:0] == LO_CMP_OR_LOAD) begin
                    // result only drives the flags for a later branch
                    n.cc[CC_N] = cmp_r[15];
                    n.cc[CC_Z] = (cmp_r[15:0] == 16'h0000);
                    n.cc[CC_V] = (s.x[15] ^ s.m[15]) &
                                 (cmp_r[15] ^ s.x[15]);
                    n.cc[CC_C] = cmp_r[16];
                end else if (s.op[7:6] == 2'h3 &&
                             s.op[3:0] == LO_SUB_OR_ADD) begin
                    {n.a, n.b} = add_r[15:0];
                    n.cc[CC_N] = add_r[15];
                    n.cc[CC_Z] = (add_r[15:0] == 16'h0000);
                    n.cc[CC_V] = ~(d[15] ^ s.m[15]) &
                                 (add_r[15] ^ d[15]);
                    n.cc[CC_C] = add_r[16];
                end else if (s.op[7:6] == 2'h3 &&
                             s.op[3:0] == LO_CMP_OR_LOAD) begin
                    // double load, handy for setting d from memory
                    {n.a, n.b} = s.m;
                    n.cc[CC_N] = s.m[15];
                    n.cc[CC_Z] = (s.m == 16'h0000);
                    n.cc[CC_V] = 1'b0;
                end else begin
                    case (s.op)
                        OP_ADD_B_TO_INDEX: begin
                            n.x = 16'(s.x + {8'h00, s.b});
                        end
                        OP_STACK_TO_INDEX: begin
                            n.x = 16'(s.sp + 16'd1);
                        end
                        OP_INDEX_TO_STACK: begin
                            n.sp = 16'(s.x - 16'd1);
                        end
                        OP_PRODUCT: begin
                            {n.a, n.b} = prod;
                            n.cc[CC_C] = prod[7];
                        end
                        OP_DOUBLE_SHIFT_LEFT: begin
                            {n.a, n.b} = shl_r;
                            n.cc[CC_C] = d[15];
                            n.cc[CC_N] = shl_r[15];
                            n.cc[CC_Z] = (shl_r == 16'h0000);
                            n.cc[CC_V] = shl_r[15] ^ d[15];
                        end
                        OP_DOUBLE_SHIFT_RIGHT: begin
                            {n.a, n.b} = shr_r;
                            n.cc[CC_C] = d[0];
                            n.cc[CC_N] = 1'b0;
                            n.cc[CC_Z] = (shr_r == 16'h0000);
                            n.cc[CC_V] = d[0];
                        end
                        // unknown opcodes act as one-byte no-ops
                        default: n.st = ST_FETCH;
                    endcase
                end
            end
            default: n.st = ST_FETCH;
        endcase

        // apb read data and error are latched in the setup cycle
        if (setup) begin
            n.perr   = 1'b0;
            n.prdata = 32'h0000_0000;
            case (paddr)
                REG_CTRL:   n.prdata = {31'h0, s.run};
                REG_STATUS: n.prdata = {16'h0, s.op, s.st,
                                        3'h0, (s.st != ST_FETCH) | s.mem.req};
                REG_DACC:   n.prdata = {16'h0, d};
                REG_INDEX:  n.prdata = {16'h0, s.x};
                REG_STACK:  n.prdata = {16'h0, s.sp};
                REG_PC:     n.prdata = {16'h0, s.pc};
                REG_CCR:    n.prdata = {24'h0, s.cc};
                default:    n.perr   = 1'b1;
            endcase
        end
        // writes land at the access edge; core registers only while stopped
        if (wr_acc) begin
            case (paddr)
                REG_CTRL: n.run = pwdata[0];
                REG_DACC: if (!s.run) {n.a, n.b} = pwdata[15:0];
                REG_INDEX: if (!s.run) n.x = pwdata[15:0];
                REG_STACK: if (!s.run) n.sp = pwdata[15:0];
                REG_PC:   if (!s.run) n.pc = pwdata[15:0];
                REG_CCR:  if (!s.run) n.cc = pwdata[7:0];
                default:  n.perr = 1'b1;
            endcase
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.st     <= ST_FETCH;
            s.op     <= 8'h00;
            s.pc     <= RST_PC;
            s.sp     <= RST_SP;
            s.x      <= 16'h0000;
            s.a      <= 8'h00;
            s.b      <= 8'h00;
            s.cc     <= RST_CCR;
            s.ea     <= 16'h0000;
            s.m      <= 16'h0000;
            s.mem    <= '0;
            s.run    <= 1'b0;
            s.prdata <= 32'h0000_0000;
            s.perr   <= 1'b0;
        end else begin
            s <= n;
        end
    end

    // outputs; slave always answers in the first access cycle
    assign pready  = 1'b1;
    assign prdata  = s.prdata;
    assign pslverr = s.perr & psel & penable;
    assign mem_o   = s.mem;

endmodule // ecd_core

// [tb/ecd_core_sva.sv]
// port checker for the 8-bit core
module ecd_core_sva (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // memory bus
    input wire ecd_pkg::ecd_mem_s mem_o,
    input wire logic              mem_ready,
    input wire logic [7:0]        mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    logic        ap;      // apb access phase
    logic        bad;     // unmapped or misaligned offset
    logic        pair_q;  // last finished access was a write
    logic [15:0] last_q;  // its address
    assign ap  = psel && penable;
    assign bad = (paddr > REG_CCR) || (paddr[1:0] != 2'h0);
    // a read in between breaks a write pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_q <= 1'b0;
            last_q <= 16'h0000;
        end else if (mem_o.req && mem_ready) begin
            pair_q <= mem_o.we;
            last_q <= mem_o.addr;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_always_ready: assert property (pready)
        else $error("pready low");
    chk_bad_refused: assert property (ap && bad |-> pslverr && prdata == 0)
        else $error("bad offset not refused");
    chk_good_taken: assert property (ap && !bad |-> !pslverr)
        else $error("error on mapped offset");
    chk_read_stands: assert property (ap ##1 !psel |-> $stable(prdata))
        else $error("read data moved after access");
    chk_req_held: assert property (mem_o.req && !mem_ready |=>
        mem_o.req && $stable(mem_o)) else $error("request not held");
    chk_req_gap: assert property (mem_o.req && mem_ready |=> !mem_o.req)
        else $error("no idle cycle after access");
    chk_write_pair: assert property (mem_o.req && mem_o.we &&
        mem_ready && pair_q |-> (mem_o.addr == last_q + 16'h1) ||
        (mem_o.addr == last_q - 16'h1)) else $error("write pair apart");
    chk_quiet_reset: assert property ($rose(presetn) |-> !mem_o.req [*4])
        else $error("request right after reset");
    cover property (mem_o.req && mem_o.we && mem_ready);
    cover property (mem_o.req && !mem_ready);
    cover property (ap && pslverr);
endmodule // ecd_core_sva

// [tb/ecd_mem_model.sv]
// byte memory standing on the core's system bus
module ecd_mem_model (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // wait states per access
    input  wire logic [1:0]        delay,
    // memory bus
    input  wire ecd_pkg::ecd_mem_s mem_o,
    output logic                   mem_ready,
    output logic [7:0]             mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    logic [7:0] ram [0:65535];  // flat byte store
    logic [1:0] cnt_q;          // waits already spent
    logic [7:0] last_q;         // last byte handed out
    // data only valid with ready; otherwise the inverse, never a stale copy
    assign mem_ready = mem_o.req && (cnt_q == delay);
    assign mem_rdata = mem_ready ? ram[mem_o.addr] : ~last_q;
    // count waits, store writes at the completing edge
    // plain always: the bench preloads the same store at time zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 2'h0;
            last_q <= 8'h00;
        end else if (mem_ready) begin
            cnt_q  <= 2'h0;
            last_q <= mem_rdata;
            if (mem_o.we) ram[mem_o.addr] <= mem_o.wdata;
        end else if (mem_o.req) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule // ecd_mem_model

// [tb/ecd_core_bench.sv]
// self-checking bench: runs a small program through the core
module ecd_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    ecd_mem_s    mem_o;
    logic        mem_ready;
    logic [7:0]  mem_rdata;
    logic [31:0] rd;              // last read data
    logic        err;             // last error flag
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // program: b into x, product, shifts, add immediate, store direct, push,
    // transfers, pull, subtract extended and indexed, branch never,
    // index compare, then a branch onto itself
    logic [7:0]  prog [] = '{8'h3a, 8'h3d, 8'h05, 8'h04, 8'hc3, 8'h10,
        8'h00, 8'hdd, 8'h80, 8'h3c, 8'h30, 8'h35, 8'h38, 8'hb3, 8'h00,
        8'h90, 8'ha3, 8'h02, 8'h21, 8'h05, 8'hac, 8'h10, 8'h20, 8'hfe};
    always #12.5 pclk = ~pclk;
    ecd_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .mem_o, .mem_ready,
        .mem_rdata);
    ecd_mem_model mem (.pclk, .presetn, .delay(2'h1), .mem_o, .mem_ready,
        .mem_rdata);
    // one apb transfer, released at the edge that completes it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(n, e, rd);
    endtask
    task automatic mchk(input logic [15:0] a, input logic [7:0] e);
        check("ram", {24'h0, e}, {24'h0, mem.ram[a]});
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard: the whole program needs well under this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        foreach (prog[i]) mem.ram[i] = prog[i];
        mem.ram[16'h90] = 8'h13;
        mem.ram[16'h91] = 8'ha9;
        mem.ram[16'h86] = 8'hff;
        mem.ram[16'h87] = 8'hff;
        mem.ram[16'h94] = 8'h00;
        mem.ram[16'h95] = 8'h84;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ccr", REG_CCR, {24'h0, RST_CCR});
        rchk("sp", REG_STACK, {16'h0, RST_SP});
        apb(1'b1, REG_DACC, 32'h1234);
        apb(1'b1, REG_INDEX, 32'h0050);
        apb(1'b1, REG_STACK, 32'h01ff);
        rchk("d", REG_DACC, 32'h1234);
        apb(1'b0, 8'h1c, 32'h0);
        check("err", 32'h1, {31'h0, err});
        apb(1'b1, REG_CTRL, 32'h1);
        // the closing branch-always only runs if branch-never fell through
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[15:8] !== 8'h20);
        apb(1'b1, REG_INDEX, 32'hdead);
        apb(1'b1, REG_CTRL, 32'h0);
        rchk("d", REG_DACC, 32'h0000);
        rchk("x", REG_INDEX, 32'h0084);
        rchk("sp", REG_STACK, 32'h01ff);
        rchk("pc", REG_PC, 32'h0016);
        apb(1'b0, REG_CCR, 32'h0);
        check("nzvc", 32'h4, {28'h0, rd[3:0]});
        mchk(16'h0080, 8'h13);
        mchk(16'h0081, 8'ha8);
        mchk(16'h01ff, 8'h84);
        mchk(16'h01fe, 8'h00);
        close_out();
    end
endmodule // ecd_core_bench
bind ecd_core ecd_core_sva chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .mem_o, .mem_ready,
    .mem_rdata);
